// ### rtl/tmr_pkg.sv
// tmr_pkg: shared constants for the 16-bit timer/counter block
// assumes one system clock of 20 MHz and plain control ports, no bus
package tmr_pkg;
	// counter width and byte layout
	localparam int unsigned CNT_W = 16;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// instruction clock is the system clock divided by four
	localparam logic [1:0] INSTR_PH_RESET = 2'h0;
	localparam logic [1:0] INSTR_PH_LAST = 2'h3;

	// prescaler: limit is (1 << select) - 1
	localparam logic [2:0] PSC_RESET = 3'h0;
	localparam logic [2:0] PSC_ONE = 3'h1;

	// system clock select code for secondary run
	localparam logic [1:0] SCS_CRYSTAL = 2'h1;

	// control register bit positions
	localparam int unsigned CTL_WIDE = 7;
	localparam int unsigned CTL_STATUS = 6;
	localparam int unsigned CTL_PS_HI = 5;
	localparam int unsigned CTL_PS_LO = 4;
	localparam int unsigned CTL_OSC = 3;
	localparam int unsigned CTL_SYNC = 2;
	localparam int unsigned CTL_SRC = 1;
	localparam int unsigned CTL_ON = 0;

	// power mode of the device
	typedef enum logic [1:0] {
		TMR_PM_RUN = 2'b00,
		TMR_PM_SEC_IDLE = 2'b01,
		TMR_PM_SLEEP = 2'b10
	} tmr_pm_t;
endpackage

// ### rtl/tmr_sync.sv
// tmr_sync: two flip-flop synchroniser for pin levels
// assumes inputs are asynchronous to clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module tmr_sync #(
	parameter int unsigned WIDTH = 2
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// levels
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	// first stage feeds only the second
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= async_i;
			sync_r <= meta_r;
		end
	end

	assign sync_o = sync_r;
endmodule
`default_nettype wire

// ### rtl/tmr_counter.sv
// tmr_counter: 16-bit timer/counter with crystal oscillator control,
// buffered 16-bit access, overflow flag and secondary clock status
// assumes cpu access strobes are one-cycle pulses on clk_sys_i
//
// Summary of operation
// R01 - sync disable bit counts external edges unsynchronised
// R02 - async counter runs in sleep, overflow wakes
// R03 - mode switch may drop or add one count
// R04 - falling edge required before first counted rise
// R05 - wide mode maps high address to buffer
// R06 - low read snapshots live high byte
// R07 - high write buffered, low write loads both
// R08 - wide mode: live high byte never accessed directly
// R09 - only low write clears prescaler in wide mode
// R10 - crystal oscillator runs only while enabled
// R11 - oscillator keeps running in power-managed modes
// R12 - software waits for oscillator start-up
// R13 - select code 01 runs system from crystal
// R14 - sleep with idle bit clear enters secondary idle
// R15 - status flag set while crystal clocks system
// R16 - monitored crystal failure shows other source
// R17 - low-power config selects oscillator power level
// R18 - counts 0000h to FFFFh, rollover is overflow
// R19 - overflow sets flag regardless of enable
// R20 - interrupt request only when enable set
// R21 - source select: instruction clock or external rise
// R22 - sync bit ignored with internal clock source
// R23 - prescale 1, 2, 4 or 8
// R24 - wide access bit at control bit 7
// R25 - flag sticky until software clears it
`timescale 1ns/1ps
`default_nettype none
module tmr_counter (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// control bits
	input wire logic timer_on_i,
	input wire logic clock_source_select_i,
	input wire logic ext_sync_disable_i,
	input wire logic [1:0] prescale_select_i,
	input wire logic crystal_osc_enable_i,
	input wire logic wide_access_mode_i,
	input wire logic crystal_low_power_cfg_i,
	// oscillator and power control
	input wire logic [1:0] system_clock_select_i,
	input wire logic idle_on_sleep_i,
	input wire logic sleep_req_i,
	input wire logic clock_monitor_en_i,
	input wire logic crystal_fail_i,
	// cpu access to the count bytes
	input wire logic wr_low_i,
	input wire logic wr_high_i,
	input wire logic rd_low_i,
	input wire logic rd_high_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	// interrupt
	input wire logic overflow_irq_enable_i,
	input wire logic overflow_irq_clear_i,
	output logic overflow_irq_flag_o,
	output logic irq_o,
	// status
	output logic crystal_clock_status_o,
	output logic [7:0] counter_control_reg_o,
	output logic [15:0] count_o,
	output tmr_pkg::tmr_pm_t power_mode_o,
	// pins
	input wire logic external_count_clock_i,
	input wire logic crystal_input_pin_i,
	output logic crystal_output_pin_o,
	output logic crystal_osc_run_o,
	output logic crystal_low_power_o
);
	import tmr_pkg::*;

	logic [15:0] count_r, count_nxt;
	logic [7:0] high_buf_r, high_buf_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic [2:0] psc_r, psc_nxt;
	logic [1:0] ph_r, ph_nxt;
	logic flag_r, flag_nxt;
	logic armed_r, armed_nxt;
	logic lvl3_r, lvl4_r;
	tmr_pm_t pm_r, pm_nxt;
	logic [1:0] pins_sync;
	logic lvl2;
	logic rise_async, fall_async, rise_sync, fall_sync;
	logic ext_rise, ext_fall, ext_mode, asleep;
	logic instr_tick, src_tick, count_tick, ovf;
	logic any_write, crystal_run;
	logic [2:0] psc_lim;

	// synchronise both pins, the oscillator input and the count pin
	tmr_sync #(
		.WIDTH(2)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.async_i({crystal_input_pin_i, external_count_clock_i}),
		.sync_o(pins_sync)
	);

	// oscillator input replaces the count pin as count source when enabled
	assign lvl2 = crystal_osc_enable_i ? pins_sync[1] : pins_sync[0];

	// extra stages: sync path lags the async path by one cycle
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			lvl3_r <= 1'b0;
			lvl4_r <= 1'b0;
		end else begin
			lvl3_r <= lvl2;
			lvl4_r <= lvl3_r;
		end
	end

	// R03 switching paths may drop or add a count
	assign rise_async = lvl2 & ~lvl3_r;
	assign fall_async = ~lvl2 & lvl3_r;
	assign rise_sync = lvl3_r & ~lvl4_r;
	assign fall_sync = ~lvl3_r & lvl4_r;

	// R01 R22 sync disable only matters with external source
	assign ext_mode = clock_source_select_i;
	assign ext_rise = ext_sync_disable_i ? rise_async : rise_sync;
	assign ext_fall = ext_sync_disable_i ? fall_async : fall_sync;

	// instruction clock phase, four system clocks per tick
	assign instr_tick = (ph_r == INSTR_PH_LAST);
	assign ph_nxt = ph_r + 2'h1;

	// full sleep stops the timer and the synchronised counter
	assign asleep = (pm_r == TMR_PM_SLEEP);
	assign any_write = wr_low_i | wr_high_i;

	// R04 arm on falling edge, disarm on write or stop
	assign armed_nxt = (!timer_on_i || !ext_mode || any_write) ? 1'b0 :
		(armed_r | ext_fall);

	// R21 R02 select the tick source, async keeps counting in sleep
	assign src_tick = !timer_on_i ? 1'b0 :
		!ext_mode ? (instr_tick & ~asleep) :
		ext_sync_disable_i ? (ext_rise & armed_r) :
		(ext_rise & armed_r & ~asleep);

	// R23 prescaler limit 0, 1, 3 or 7
	assign psc_lim = (PSC_ONE << prescale_select_i) - PSC_ONE;
	assign count_tick = src_tick && (psc_r == psc_lim);

	// R09 prescaler cleared by low write, or high write in byte mode
	assign psc_nxt = (wr_low_i || (wr_high_i && !wide_access_mode_i)) ?
		PSC_RESET : (count_tick ? PSC_RESET :
		(src_tick ? psc_r + PSC_ONE : psc_r));

	// R18 overflow on rollover from the top value
	assign ovf = count_tick && (count_r == CNT_MAX) && !any_write;

	// R05 R07 R08 writes: high goes to buffer in wide mode
	always_comb begin
		count_nxt = count_tick ? count_r + 16'h0001 : count_r;
		high_buf_nxt = high_buf_r;
		if (wide_access_mode_i) begin
			if (wr_high_i) begin
				high_buf_nxt = wdata_i;
			end
			if (wr_low_i) begin
				count_nxt = {wr_high_i ? wdata_i : high_buf_r, wdata_i};
			end else if (rd_low_i && !wr_high_i) begin
				// R06 snapshot high byte on low read
				high_buf_nxt = count_r[15:8];
			end
		end else begin
			if (wr_high_i) begin
				count_nxt[15:8] = wdata_i;
			end
			if (wr_low_i) begin
				count_nxt[7:0] = wdata_i;
			end
		end
	end

	// R08 read path: high address reads the buffer in wide mode
	assign rdata_nxt = rd_low_i ? count_r[7:0] :
		!rd_high_i ? rdata_r :
		wide_access_mode_i ? high_buf_r : count_r[15:8];

	// R19 R25 sticky flag, a new overflow wins over the clear
	assign flag_nxt = ovf | (flag_r & ~overflow_irq_clear_i);

	// R13 R16 crystal clocks system unless monitored failure
	assign crystal_run = (system_clock_select_i == SCS_CRYSTAL) &&
		crystal_osc_enable_i && !(clock_monitor_en_i && crystal_fail_i);

	// R14 R02 power modes, interrupt request wakes the device
	always_comb begin
		pm_nxt = pm_r;
		case (pm_r)
			TMR_PM_RUN: begin
				if (sleep_req_i) begin
					pm_nxt = (crystal_run && !idle_on_sleep_i) ?
						TMR_PM_SEC_IDLE : TMR_PM_SLEEP;
				end
			end
			TMR_PM_SEC_IDLE: begin
				if (irq_o || !crystal_run) begin
					pm_nxt = TMR_PM_RUN;
				end
			end
			TMR_PM_SLEEP: begin
				if (irq_o) begin
					pm_nxt = TMR_PM_RUN;
				end
			end
			default: begin
				pm_nxt = TMR_PM_RUN;
			end
		endcase
	end

	// state registers
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			count_r <= CNT_RESET;
			high_buf_r <= BYTE_ZERO;
			rdata_r <= BYTE_ZERO;
			psc_r <= PSC_RESET;
			ph_r <= INSTR_PH_RESET;
			flag_r <= 1'b0;
			armed_r <= 1'b0;
			pm_r <= TMR_PM_RUN;
		end else begin
			count_r <= count_nxt;
			high_buf_r <= high_buf_nxt;
			rdata_r <= rdata_nxt;
			psc_r <= psc_nxt;
			ph_r <= ph_nxt;
			flag_r <= flag_nxt;
			armed_r <= armed_nxt;
			pm_r <= pm_nxt;
		end
	end

	// R20 request gated by the enable
	assign irq_o = flag_r & overflow_irq_enable_i;
	assign overflow_irq_flag_o = flag_r;
	assign rdata_o = rdata_r;
	assign count_o = count_r;
	assign power_mode_o = pm_r;

	// R15 status follows the system clock source
	assign crystal_clock_status_o = crystal_run;

	// R24 control readback, wide mode at bit 7
	always_comb begin
		counter_control_reg_o = BYTE_ZERO;
		counter_control_reg_o[CTL_WIDE] = wide_access_mode_i;
		counter_control_reg_o[CTL_STATUS] = crystal_run;
		counter_control_reg_o[CTL_PS_HI] = prescale_select_i[1];
		counter_control_reg_o[CTL_PS_LO] = prescale_select_i[0];
		counter_control_reg_o[CTL_OSC] = crystal_osc_enable_i;
		counter_control_reg_o[CTL_SYNC] = ext_sync_disable_i;
		counter_control_reg_o[CTL_SRC] = clock_source_select_i;
		counter_control_reg_o[CTL_ON] = timer_on_i;
	end

	// R10 R11 amplifier driven only by the enable, never by power mode
	assign crystal_osc_run_o = crystal_osc_enable_i;
	assign crystal_output_pin_o = crystal_osc_enable_i & ~pins_sync[1];

	// R17 power level from the configuration bit
	assign crystal_low_power_o = crystal_osc_enable_i & crystal_low_power_cfg_i;

	// checks
	a_ovf_sets_flag: assert property (@(posedge clk_sys_i) // R19
		disable iff (!reset_n_i) ovf |=> flag_r)
		else $error("overflow did not set flag");

	a_flag_sticky: assert property (@(posedge clk_sys_i) // R25
		disable iff (!reset_n_i)
		flag_r && !overflow_irq_clear_i |=> flag_r)
		else $error("flag dropped without clear");

	a_irq_gate: assert property (@(posedge clk_sys_i) // R20
		disable iff (!reset_n_i)
		irq_o |-> (flag_r && overflow_irq_enable_i))
		else $error("irq without flag and enable");

	a_low_snapshot: assert property (@(posedge clk_sys_i) // R06
		disable iff (!reset_n_i)
		wide_access_mode_i && rd_low_i && !any_write
		|=> high_buf_r == $past(count_r[15:8]))
		else $error("low read did not snapshot high byte");

	a_wide_load: assert property (@(posedge clk_sys_i) // R07
		disable iff (!reset_n_i)
		wide_access_mode_i && wr_low_i && !wr_high_i
		|=> count_r == {$past(high_buf_r), $past(wdata_i)})
		else $error("low write did not load both bytes");

	a_high_buffered: assert property (@(posedge clk_sys_i) // R05
		disable iff (!reset_n_i)
		wide_access_mode_i && wr_high_i && !wr_low_i && !count_tick
		|=> count_r == $past(count_r) && high_buf_r == $past(wdata_i))
		else $error("high write reached live counter");

	a_psc_keep: assert property (@(posedge clk_sys_i) // R09
		disable iff (!reset_n_i)
		wide_access_mode_i && wr_high_i && !wr_low_i && !src_tick
		|=> psc_r == $past(psc_r))
		else $error("high write cleared prescaler");

	a_psc_clear: assert property (@(posedge clk_sys_i) // R09
		disable iff (!reset_n_i) wr_low_i |=> psc_r == PSC_RESET)
		else $error("low write kept prescaler");

	a_arm_first: assert property (@(posedge clk_sys_i) // R04
		disable iff (!reset_n_i)
		ext_mode && !armed_r && !any_write |=> count_r == $past(count_r))
		else $error("count before falling edge");

	a_sleep_stop: assert property (@(posedge clk_sys_i) // R02
		disable iff (!reset_n_i)
		asleep && !(ext_mode && ext_sync_disable_i) && !any_write
		|=> count_r == $past(count_r))
		else $error("timer counted in sleep");

	a_status_scs: assert property (@(posedge clk_sys_i) // R15
		disable iff (!reset_n_i)
		system_clock_select_i != SCS_CRYSTAL |-> !crystal_clock_status_o)
		else $error("status set with other source");

	a_osc_off: assert property (@(posedge clk_sys_i) // R10
		disable iff (!reset_n_i)
		!crystal_osc_enable_i |-> !crystal_output_pin_o && !crystal_osc_run_o)
		else $error("oscillator driven while disabled");
endmodule
`default_nettype wire

// ### testbench/tmr_far_side.sv
// tmr_far_side: count pin burst source and crystal feedback loop
// assumes go_i rises once per burst and pulses_i is stable then
`timescale 1ns/1ps
`default_nettype none
module tmr_far_side (
	// burst request
	input wire logic go_i,
	input wire logic [7:0] pulses_i,
	// pins
	input wire logic xtal_out_i,
	output logic count_pin_o,
	output logic xtal_in_o
);
	initial begin
		count_pin_o = 1'b0;
		xtal_in_o = 1'b0;
	end
	// rise then fall, pin stands low between bursts
	always @(posedge go_i) begin
		repeat (pulses_i) begin
			#337 count_pin_o = 1'b1;
			#337 count_pin_o = 1'b0;
		end
	end
	// crystal echoes the amplifier output after half a period
	always @(xtal_out_i) begin
		xtal_in_o <= #15000 xtal_out_i;
	end
endmodule
`default_nettype wire

// ### testbench/timer1_async_counter_rw16_tb.sv
// timer1_async_counter_rw16_tb: self-checking bench for tmr_counter
// assumes the far side model drives the count and crystal pins
`timescale 1ns/1ps
`default_nettype none
module timer1_async_counter_rw16_tb;
	import tmr_pkg::*;
	logic clk_sys_i, reset_n_i, on, src, sdis, osc, wide, lpc, idl, slp;
	logic mon, fail, wl, wh, rl, rh, ien, iclr, go, fl, irq, st, xo;
	logic orun, olp, cpin, xin;
	logic [1:0] ps, scs;
	logic [7:0] wd, rd, ctl;
	logic [15:0] cnt, m_cnt, rv;
	tmr_pm_t pm;
	int err_total = 0;
	int checked = 0;
	tmr_counter dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
		.timer_on_i(on), .clock_source_select_i(src),
		.ext_sync_disable_i(sdis), .prescale_select_i(ps),
		.crystal_osc_enable_i(osc), .wide_access_mode_i(wide),
		.crystal_low_power_cfg_i(lpc), .system_clock_select_i(scs),
		.idle_on_sleep_i(idl), .sleep_req_i(slp),
		.clock_monitor_en_i(mon), .crystal_fail_i(fail),
		.wr_low_i(wl), .wr_high_i(wh), .rd_low_i(rl), .rd_high_i(rh),
		.wdata_i(wd), .rdata_o(rd), .overflow_irq_enable_i(ien),
		.overflow_irq_clear_i(iclr), .overflow_irq_flag_o(fl),
		.irq_o(irq), .crystal_clock_status_o(st),
		.counter_control_reg_o(ctl), .count_o(cnt), .power_mode_o(pm),
		.external_count_clock_i(cpin), .crystal_input_pin_i(xin),
		.crystal_output_pin_o(xo), .crystal_osc_run_o(orun),
		.crystal_low_power_o(olp));
	tmr_far_side far (.go_i(go), .pulses_i(wd), .xtal_out_i(xo),
		.count_pin_o(cpin), .xtal_in_o(xin));
	// free-running system clock
	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	// exact and plus-minus-one comparisons
	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic check_near(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp && got !== exp + 16'h1 && got !== exp - 16'h1) begin
			err_total++;
			$display("BAD %0t count %h near %h", $time, got, exp);
		end
	endtask
	// one-cycle strobe: 0 wr low, 1 wr high, 2 rd low, 3 rd high,
	// 4 sleep, 5 flag clear, 6 pin burst of d pulses
	task automatic acc(input int k, input logic [7:0] d);
		@(posedge clk_sys_i);
		wd <= d;
		{wl, wh, rl, rh} <= {k == 0, k == 1, k == 2, k == 3};
		{slp, iclr, go} <= {k == 4, k == 5, k == 6};
		@(posedge clk_sys_i);
		{wl, wh, rl, rh, slp, iclr, go} <= 7'h00;
		#1;
	endtask
	task automatic wr16(input logic [15:0] v);
		acc(1, v[15:8]);
		acc(0, v[7:0]);
		m_cnt = v;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic give_verdict;
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// watchdog well beyond the expected run of about 9500 cycles
	initial begin
		repeat (40000) @(posedge clk_sys_i);
		err_total++;
		$display("BAD %0t watchdog expired", $time);
		give_verdict();
	end
	initial begin
		void'($urandom(32'h0d9abacf));
		{on, src, sdis, osc, wide, lpc, idl, slp, mon, fail} = 10'h000;
		{wl, wh, rl, rh, ien, iclr, go, ps, scs, wd} = 19'h00000;
		reset_n_i = 1'b0;
		repeat (5) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		cyc(1);
		check_val(cnt, 16'h0000);
		check_val({13'h0, fl, pm}, {13'h0, 1'b0, TMR_PM_RUN});
		check_val({15'h0, xo}, 16'h0000);
		// buffered high byte with the count stopped
		rv = 16'($urandom());
		@(posedge clk_sys_i);
		wide <= 1'b1;
		wr16(rv);
		check_val(cnt, m_cnt);
		acc(1, ~rv[15:8]);
		check_val(cnt, m_cnt);
		acc(2, 8'h00);
		check_val({8'h0, rd}, {8'h0, m_cnt[7:0]});
		acc(3, 8'h00);
		check_val({8'h0, rd}, {8'h0, m_cnt[15:8]});
		@(posedge clk_sys_i);
		wide <= 1'b0;
		acc(1, 8'h5a);
		m_cnt[15:8] = 8'h5a;
		check_val(cnt, m_cnt);
		// timer mode: each prescale code divides the instruction clock
		@(posedge clk_sys_i);
		{wide, on} <= 2'b11;
		for (int k = 0; k < 4; k++) begin
			@(posedge clk_sys_i);
			ps <= 2'(k);
			wr16(16'h0000);
			cyc(40 << k);
			check_near(cnt, 16'h000a);
		end
		// overflow sets the sticky flag, the request follows the enable
		@(posedge clk_sys_i);
		ps <= 2'h0;
		wr16(16'hfff0);
		cyc(80);
		check_near(cnt, 16'h0004);
		check_val({14'h0, fl, irq}, 16'h0002);
		@(posedge clk_sys_i);
		ien <= 1'b1;
		cyc(20);
		check_val({14'h0, fl, irq}, 16'h0003);
		acc(5, 8'h00);
		check_val({15'h0, fl}, 16'h0000);
		// pin edges, sync and async, first rise waits for a fall
		@(posedge clk_sys_i);
		src <= 1'b1;
		for (int j = 0; j < 4; j++) begin
			@(posedge clk_sys_i);
			{sdis, ps} <= {j[0], 1'b0, j[1]};
			wr16(16'h0000);
			acc(6, 8'd9);
			cyc(150);
			check_val(cnt, 16'(8 >> j[1]));
		end
		// crystal clocks the system, sleep picks idle or full sleep
		@(posedge clk_sys_i);
		{osc, lpc, sdis, idl, ps} <= 6'b111000;
		scs <= SCS_CRYSTAL;
		cyc(1);
		check_val({14'h0, orun, olp}, 16'h0003);
		check_val({8'h0, ctl}, {8'h0, wide, 1'b1, ps, osc, sdis, src, on});
		cyc(2000);
		wr16(16'hfffe);
		acc(4, 8'h00);
		check_val({13'h0, st, pm}, {13'h0, 1'b1, TMR_PM_SEC_IDLE});
		cyc(3000);
		check_val({13'h0, fl, pm}, {13'h0, 1'b1, TMR_PM_RUN});
		acc(5, 8'h00);
		@(posedge clk_sys_i);
		{mon, fail} <= 2'b11;
		cyc(1);
		check_val({15'h0, st}, 16'h0000);
		@(posedge clk_sys_i);
		{fail, idl} <= 2'b01;
		wr16(16'hfffe);
		acc(4, 8'h00);
		check_val({14'h0, pm}, {14'h0, TMR_PM_SLEEP});
		cyc(3000);
		check_val({13'h0, fl, pm}, {13'h0, 1'b1, TMR_PM_RUN});
		@(posedge clk_sys_i);
		osc <= 1'b0;
		cyc(1);
		check_val({13'h0, orun, xo, st}, 16'h0000);
		// timer mode halts in full sleep, a reset brings it back to run
		@(posedge clk_sys_i);
		src <= 1'b0;
		acc(5, 8'h00);
		rv = 16'($urandom()) & 16'h7fff;
		wr16(rv);
		acc(4, 8'h00);
		check_val({14'h0, pm}, {14'h0, TMR_PM_SLEEP});
		cyc(40);
		check_near(cnt, m_cnt);
		@(posedge clk_sys_i);
		reset_n_i <= 1'b0;
		repeat (5) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		cyc(1);
		check_val({13'h0, fl, pm}, {13'h0, 1'b0, TMR_PM_RUN});
		check_val(cnt, 16'h0000);
		give_verdict();
	end
endmodule
`default_nettype wire
